// >>> hw/bmcs_pkg.sv
// Constants for the boot mode and boot clock selection block
package bmcs_pkg;

    // ==========================================
    // Start addresses
    localparam logic [31:0] ADDR_BOOT_ROM  = 32'h0010_0000;
    localparam logic [31:0] ADDR_CS2_SPACE = 32'h4200_0000;

    // ==========================================
    // Boot mode codes
    localparam logic [3:0] MODE_NO_BOOT    = 4'h0;
    localparam logic [3:0] MODE_PCI_NOAUTO = 4'h1;
    localparam logic [3:0] MODE_PCI_AUTO   = 4'h2;
    localparam logic [3:0] MODE_RSV_3      = 4'h3;
    localparam logic [3:0] MODE_ROM        = 4'h4;
    localparam logic [3:0] MODE_NAND       = 4'h7;
    localparam logic [3:0] MODE_ROM_NOAIS  = 4'h9;
    localparam logic [3:0] MODE_RSV_B      = 4'hb;
    localparam logic [3:0] MODE_RSV_C      = 4'hc;
    localparam logic [3:0] MODE_RSV_D      = 4'hd;

    // ==========================================
    // Pinout select codes
    localparam logic [2:0] PINOUT_MODE_2 = 3'h2;
    localparam logic [2:0] PINOUT_MODE_5 = 3'h5;

    // ==========================================
    // Multipliers and dividers
    localparam logic [4:0] MULT_BYPASS  = 5'h01;
    localparam logic [4:0] MULT_X20     = 5'h14;
    localparam logic [4:0] MULT_X15     = 5'h0f;
    localparam logic [4:0] MULT_X16     = 5'h10;
    localparam logic [4:0] MULT_X18     = 5'h12;
    localparam logic [4:0] MULT_X22     = 5'h16;
    localparam logic [4:0] MULT_X25     = 5'h19;
    localparam logic [4:0] MULT_X27     = 5'h1b;
    localparam logic [4:0] MULT_X30     = 5'h1e;
    localparam logic [1:0] DIV_BY_1     = 2'h1;
    localparam logic [1:0] DIV_BY_2     = 2'h2;

    // ==========================================
    // Capture register layout
    localparam int CAP_MODE_LSB   = 0;
    localparam int CAP_PINOUT_LSB = 8;
    localparam int CAP_MULT_LSB   = 12;
    localparam int CAP_PCI_BIT    = 17;
    localparam int CAP_FAST_BIT   = 19;
    localparam logic [31:0] CAP_RESET = 32'h0000_0000;

    // ==========================================
    // Interface settings
    localparam logic [1:0] IF_ASYNC = 2'h0;
    localparam logic [1:0] IF_NAND  = 2'h1;
    localparam logic [1:0] IF_OFF   = 2'h2;
    localparam logic [3:0] ASYNC_TIMING_SLOWEST = 4'hf;

    // ==========================================
    // Boot sequence states
    typedef enum logic [2:0] {
        ST_RESET   = 3'b000,
        ST_DECODE  = 3'b001,
        ST_PLL     = 3'b011,
        ST_CACHE   = 3'b010,
        ST_FETCH   = 3'b110,
        ST_DONE    = 3'b111,
        ST_INVALID = 3'b101
    } bmcs_state_t;

endpackage

// >>> hw/bmcs_mult_lut.sv
// Multiplier select code to PLL multiplier lookup
`timescale 1ns/1ps
module bmcs_mult_lut (
    // Select code
    input  wire logic [2:0] i_code,
    // Multiplier
    output wire logic [4:0] o_mult
);
    // ==========================================
    // Lookup
    logic [4:0] table_value;

    always_comb begin
        case (i_code)
            3'h0:    table_value = bmcs_pkg::MULT_X20;
            3'h1:    table_value = bmcs_pkg::MULT_X15;
            3'h2:    table_value = bmcs_pkg::MULT_X16;
            3'h3:    table_value = bmcs_pkg::MULT_X18;
            3'h4:    table_value = bmcs_pkg::MULT_X22;
            3'h5:    table_value = bmcs_pkg::MULT_X25;
            3'h6:    table_value = bmcs_pkg::MULT_X27;
            default: table_value = bmcs_pkg::MULT_X30;
        endcase
    end

    assign o_mult = table_value;
endmodule

// >>> hw/bmcs_boot_ctrl.sv
// Boot strap capture, start address choice and boot clock sequencing
// How it works
// - Fast boot maps the select code to x15..x30, core clock is PLL output halved
// - Start address is boot ROM for every mode except direct ROM boot
// - Mode 0100b with fast boot clear starts at chip select two space
// - Core release pulses right after capture, fetching at chosen start address
// - After reset both PLL controllers sit in bypass, reference clock drives chip
// - Async interface timing resets to its slowest setting
// - Fast boot switches system PLL into PLL mode before any external fetch
// - Second PLL controller stays in bypass in every mode
// - Sequence decodes mode, fast boot, PCI enable and multiplier select
// - Every boot ROM mode disables all caches before the routine exits
// - Direct ROM boot keeps PLL bypass with interface in async memory mode
// - Mode 0100b with fast boot raises PLL then reads image script from space two
// - Mode 1001b raises PLL then jumps to space two base for direct fetch
// - NAND boot uses NAND interface, image script; pinout 010b or 101b
// - Straps sampled as reset releases, held in read-only capture register
`timescale 1ns/1ps
module bmcs_boot_ctrl (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    // Strap pins
    input  wire logic [3:0]  i_boot_mode_pins,
    input  wire logic        i_fast_boot_pin,
    input  wire logic        i_pci_enable_pin,
    input  wire logic [2:0]  i_pll_multiplier_select_pins,
    input  wire logic [2:0]  i_async_pinout_select_pins,
    // Boot routine progress
    input  wire logic        i_pll_locked,
    input  wire logic        i_cache_off_done,
    // Capture and start address
    output logic      [31:0] o_boot_strap_capture,
    output logic      [31:0] o_core_start_address,
    output logic             o_core_release,
    // System PLL controller
    output logic             o_system_pll_enable,
    output logic      [4:0]  o_system_pll_mult,
    output logic      [1:0]  o_core_clock_divider,
    // Second PLL controller
    output logic             o_second_pll_enable,
    // Caches and memory interface
    output logic             o_cache_disable,
    output logic      [1:0]  o_async_if_mode,
    output logic      [3:0]  o_async_timing,
    output logic             o_image_script_fetch,
    output logic      [31:0] o_fetch_address,
    output logic             o_fetch_start,
    // Status
    output logic             o_pinout_mismatch,
    output logic             o_boot_invalid,
    output logic             o_boot_done
);
    // ==========================================
    // Strap synchroniser, three stages
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] sync3;
    logic [11:0] pin_bus;

    assign pin_bus = {i_async_pinout_select_pins, i_pll_multiplier_select_pins,
                      i_pci_enable_pin, i_fast_boot_pin, i_boot_mode_pins};

    always_ff @(posedge i_clk_sys) begin
        sync1 <= pin_bus;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Straps only count once two stages agree
    logic [11:0] strap_val;
    logic        strap_stable;
    assign strap_val    = sync3;
    assign strap_stable = (sync2 == sync3);

    // ==========================================
    // Capture on reset release
    logic        captured;
    logic [3:0]  cap_mode;
    logic        cap_fast;
    logic        cap_pci;
    logic [2:0]  cap_mult_code;
    logic [2:0]  cap_pinout;
    logic        take_straps;

    // Reset leaves the straps uncaptured; sampled on first stable cycle after
    assign take_straps = !captured && strap_stable;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            captured      <= 1'b0;
            cap_mode      <= 4'h0;
            cap_fast      <= 1'b0;
            cap_pci       <= 1'b0;
            cap_mult_code <= 3'h0;
            cap_pinout    <= 3'h0;
        end else if (take_straps) begin
            captured      <= 1'b1;
            cap_mode      <= strap_val[3:0];
            cap_fast      <= strap_val[4];
            cap_pci       <= strap_val[5];
            cap_mult_code <= strap_val[8:6];
            cap_pinout    <= strap_val[11:9];
        end
    end

    // Read-only image of the latched values
    logic [31:0] cap_word;
    always_comb begin
        cap_word = bmcs_pkg::CAP_RESET;
        cap_word[bmcs_pkg::CAP_MODE_LSB +: 4]   = cap_mode;
        cap_word[bmcs_pkg::CAP_PINOUT_LSB +: 3] = cap_pinout;
        cap_word[bmcs_pkg::CAP_MULT_LSB +: 3]   = cap_mult_code;
        cap_word[bmcs_pkg::CAP_PCI_BIT]         = cap_pci;
        cap_word[bmcs_pkg::CAP_FAST_BIT]        = cap_fast;
    end

    // ==========================================
    // Mode decode
    logic [4:0]  lut_mult;

    bmcs_mult_lut u_mult_lut (
        .i_code (cap_mult_code),
        .o_mult (lut_mult)
    );

    wire mode_direct   = (cap_mode == bmcs_pkg::MODE_ROM) && !cap_fast;
    wire mode_rom_ais  = (cap_mode == bmcs_pkg::MODE_ROM) && cap_fast;
    wire mode_rom_nais = (cap_mode == bmcs_pkg::MODE_ROM_NOAIS) && cap_fast;
    wire mode_nand     = (cap_mode == bmcs_pkg::MODE_NAND);
    wire mode_pci      = (cap_mode == bmcs_pkg::MODE_PCI_NOAUTO)
                       || (cap_mode == bmcs_pkg::MODE_PCI_AUTO);

    // Reserved codes, incl. PCI code 0010b without PCI enable
    wire mode_reserved = (cap_mode == bmcs_pkg::MODE_RSV_3)
                       || (cap_mode == bmcs_pkg::MODE_RSV_B)
                       || (cap_mode == bmcs_pkg::MODE_RSV_C)
                       || (cap_mode == bmcs_pkg::MODE_RSV_D)
                       || ((cap_mode == bmcs_pkg::MODE_PCI_AUTO) && !cap_pci)
                       || ((cap_mode == bmcs_pkg::MODE_ROM_NOAIS) && !cap_fast)
                       || (mode_pci && cap_pci && !cap_fast);

    // PLL raised only for fast boot on a valid mode
    wire want_pll = cap_fast && !mode_reserved;

    wire [31:0] start_addr = mode_direct ? bmcs_pkg::ADDR_CS2_SPACE
                                         : bmcs_pkg::ADDR_BOOT_ROM;

    wire need_fetch = mode_rom_ais || mode_rom_nais || mode_nand;
    wire uses_ais   = mode_rom_ais || mode_nand;

    wire pin_ok = mode_nand
                ? ((cap_pinout == bmcs_pkg::PINOUT_MODE_2)
                   || (cap_pinout == bmcs_pkg::PINOUT_MODE_5))
                : (cap_pinout == bmcs_pkg::PINOUT_MODE_2);
    wire pin_bad = (mode_direct || mode_rom_ais || mode_rom_nais || mode_nand) && !pin_ok;

    // ==========================================
    // Boot sequence
    bmcs_pkg::bmcs_state_t state;
    bmcs_pkg::bmcs_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            bmcs_pkg::ST_RESET: begin
                if (take_straps) begin
                    next_state = bmcs_pkg::ST_DECODE;
                end
            end
            bmcs_pkg::ST_DECODE: begin
                if (mode_reserved) begin
                    next_state = bmcs_pkg::ST_INVALID;
                end else if (mode_direct) begin
                    next_state = bmcs_pkg::ST_DONE;
                end else if (want_pll) begin
                    next_state = bmcs_pkg::ST_PLL;
                end else begin
                    next_state = bmcs_pkg::ST_CACHE;
                end
            end
            // Wait for lock before any external fetch
            bmcs_pkg::ST_PLL: begin
                if (i_pll_locked) begin
                    next_state = bmcs_pkg::ST_CACHE;
                end
            end
            // Caches off before leaving the routine
            bmcs_pkg::ST_CACHE: begin
                if (i_cache_off_done) begin
                    next_state = need_fetch ? bmcs_pkg::ST_FETCH : bmcs_pkg::ST_DONE;
                end
            end
            bmcs_pkg::ST_FETCH: next_state = bmcs_pkg::ST_DONE;
            default:            next_state = state;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state <= bmcs_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // Output registers
    wire in_decode = (state == bmcs_pkg::ST_DECODE);
    wire go_pll    = in_decode && want_pll && !mode_reserved;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            // Bypass, reference clock, slowest interface timing
            o_core_start_address <= bmcs_pkg::ADDR_BOOT_ROM;
            o_core_release       <= 1'b0;
            o_system_pll_enable  <= 1'b0;
            o_system_pll_mult    <= bmcs_pkg::MULT_BYPASS;
            o_core_clock_divider <= bmcs_pkg::DIV_BY_1;
            o_cache_disable      <= 1'b0;
            o_async_if_mode      <= bmcs_pkg::IF_ASYNC;
            o_async_timing       <= bmcs_pkg::ASYNC_TIMING_SLOWEST;
            o_image_script_fetch <= 1'b0;
            o_fetch_address      <= bmcs_pkg::ADDR_BOOT_ROM;
            o_fetch_start        <= 1'b0;
            o_pinout_mismatch    <= 1'b0;
            o_boot_invalid       <= 1'b0;
            o_boot_done          <= 1'b0;
        end else begin
            // Core released at once, one-cycle pulse
            o_core_release <= in_decode && !mode_reserved;
            o_fetch_start  <= (state == bmcs_pkg::ST_FETCH);
            if (in_decode) begin
                o_core_start_address <= start_addr;
                o_pinout_mismatch    <= pin_bad;
                o_boot_invalid       <= mode_reserved;
                o_async_if_mode      <= mode_nand ? bmcs_pkg::IF_NAND : bmcs_pkg::IF_ASYNC;
                o_image_script_fetch <= uses_ais;
                o_fetch_address      <= mode_rom_nais ? bmcs_pkg::ADDR_CS2_SPACE
                                                      : (need_fetch ? bmcs_pkg::ADDR_CS2_SPACE
                                                                    : bmcs_pkg::ADDR_BOOT_ROM);
            end
            // PLL mode with selected multiplier, core clock halved
            if (go_pll) begin
                o_system_pll_enable  <= 1'b1;
                o_system_pll_mult    <= lut_mult;
                o_core_clock_divider <= bmcs_pkg::DIV_BY_2;
            end
            // Caches off in every boot ROM mode
            if (state == bmcs_pkg::ST_CACHE) begin
                o_cache_disable <= 1'b1;
            end
            if (next_state == bmcs_pkg::ST_DONE && state != bmcs_pkg::ST_DONE) begin
                o_boot_done <= 1'b1;
            end
        end
    end

    // Second PLL controller never leaves bypass
    assign o_second_pll_enable  = 1'b0;
    assign o_boot_strap_capture = cap_word;
endmodule

// >>> verification/bmcs_boot_env.sv
// Far-side model: PLL lock and cache acknowledge after a set delay
`timescale 1ns/1ps
module bmcs_boot_env (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    // Delay setting
    input  wire logic [3:0] i_delay,
    // Requests and answers
    input  wire logic       i_pll_enable,
    input  wire logic       i_cache_disable,
    output logic            o_pll_locked,
    output logic            o_cache_off_done
);
    logic [3:0] pll_cnt;
    logic [3:0] cache_cnt;
    // Never early: a slow lock must hold the fetch back
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !i_pll_enable) pll_cnt <= 4'h0;
        else if (pll_cnt != i_delay) pll_cnt <= pll_cnt + 4'h1;
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !i_cache_disable) cache_cnt <= 4'h0;
        else if (cache_cnt != i_delay) cache_cnt <= cache_cnt + 4'h1;
    end
    assign o_pll_locked     = i_pll_enable && (pll_cnt == i_delay);
    assign o_cache_off_done = i_cache_disable && (cache_cnt == i_delay);
endmodule

// >>> verification/bmcs_checker.sv
// Assertions on the boot mode and clock selection ports
`timescale 1ns/1ps
module bmcs_checker (
    // Clock, reset and lock
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_pll_locked,
    // Observed outputs
    input wire logic [31:0] o_boot_strap_capture,
    input wire logic [31:0] o_core_start_address,
    input wire logic        o_core_release,
    input wire logic        o_system_pll_enable,
    input wire logic [4:0]  o_system_pll_mult,
    input wire logic [1:0]  o_core_clock_divider,
    input wire logic        o_second_pll_enable,
    input wire logic        o_cache_disable,
    input wire logic [1:0]  o_async_if_mode,
    input wire logic [3:0]  o_async_timing,
    input wire logic        o_image_script_fetch,
    input wire logic [31:0] o_fetch_address,
    input wire logic        o_fetch_start,
    input wire logic        o_pinout_mismatch,
    input wire logic        o_boot_invalid,
    input wire logic        o_boot_done
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // ==========================================
    // Helpers
    localparam logic [4:0] MTAB [8] = '{5'h14, 5'h0f, 5'h10, 5'h12, 5'h16, 5'h19, 5'h1b, 5'h1e};
    logic [3:0] mode;
    logic       fast;
    assign mode = o_boot_strap_capture[3:0];
    assign fast = o_boot_strap_capture[19];
    // ==========================================
    // Properties
    a_start_addr_choice: assert property (o_core_release |-> o_core_start_address ==
        ((mode == 4'h4 && !fast) ? 32'h4200_0000 : 32'h0010_0000)) else $error("start address");
    a_release_one_cycle: assert property (o_core_release |=> !o_core_release)
        else $error("release pulse too long");
    a_bypass_after_reset: assert property ($fell(i_reset) |-> !o_system_pll_enable &&
        o_system_pll_mult == 5'h01 && o_core_clock_divider == 2'h1) else $error("not in bypass");
    a_fixed_slow_outputs: assert property (!o_second_pll_enable && o_async_timing == 4'hf)
        else $error("second pll or timing");
    a_fast_mult_map: assert property (o_system_pll_enable |-> o_core_clock_divider == 2'h2 &&
        o_system_pll_mult == MTAB[o_boot_strap_capture[14:12]]) else $error("multiplier");
    a_lock_before_fetch: assert property (o_fetch_start && fast |->
        o_system_pll_enable && i_pll_locked) else $error("fetch before lock");
    a_cache_before_fetch: assert property (o_fetch_start |-> o_cache_disable)
        else $error("caches still on");
    a_invalid_stays_idle: assert property (o_boot_invalid |->
        !o_core_release && !o_boot_done && !o_fetch_start) else $error("reserved mode ran");
    a_direct_rom_bypass: assert property (o_boot_done && mode == 4'h4 && !fast |->
        !o_system_pll_enable && !o_cache_disable && o_async_if_mode == 2'h0)
        else $error("direct boot setup");
    a_rom_fetch_setup: assert property (o_fetch_start && (mode == 4'h4 || mode == 4'h9) |->
        o_fetch_address == 32'h4200_0000 && o_async_if_mode == 2'h0 &&
        o_image_script_fetch == (mode == 4'h4)) else $error("rom fetch setup");
    a_nand_fetch_setup: assert property (o_fetch_start && mode == 4'h7 |->
        o_async_if_mode == 2'h1 && o_image_script_fetch && o_fetch_address == 32'h4200_0000)
        else $error("nand fetch setup");
    a_capture_held: assert property (o_core_release |=> $stable(o_boot_strap_capture) [*8])
        else $error("capture changed");
    a_pinout_strap_flag: assert property (o_core_release |-> o_pinout_mismatch ==
        ((mode == 4'h4 || mode == 4'h9 || mode == 4'h7) && o_boot_strap_capture[10:8] != 3'h2
        && !(mode == 4'h7 && o_boot_strap_capture[10:8] == 3'h5))) else $error("pinout flag");
endmodule

bind bmcs_boot_ctrl bmcs_checker i_bmcs_checker (.*);

// >>> verification/boot_mode_clock_select_bench.sv
// Self-checking testbench for boot mode and boot clock selection
`timescale 1ns/1ps
module boot_mode_clock_select_bench;
    typedef struct packed {
        logic [3:0] mode;
        logic       fast;
        logic       pci;
        logic [2:0] ms;
        logic [2:0] pin;
        logic       inv;
    } bmcs_row_t;
    // ==========================================
    // Signals
    logic        i_clk_sys = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  i_boot_mode_pins = 4'h0;
    logic        i_fast_boot_pin = 1'b0;
    logic        i_pci_enable_pin = 1'b0;
    logic [2:0]  i_pll_multiplier_select_pins = 3'h0;
    logic [2:0]  i_async_pinout_select_pins = 3'h2;
    logic [3:0]  delay = 4'h2;
    logic        i_pll_locked;
    logic        i_cache_off_done;
    logic [31:0] o_boot_strap_capture, o_core_start_address, o_fetch_address;
    logic        o_core_release, o_system_pll_enable, o_second_pll_enable, o_cache_disable;
    logic [4:0]  o_system_pll_mult;
    logic [1:0]  o_core_clock_divider, o_async_if_mode;
    logic [3:0]  o_async_timing;
    logic        o_image_script_fetch, o_fetch_start, o_pinout_mismatch;
    logic        o_boot_invalid, o_boot_done;
    int          fails = 0;
    int          checks = 0;
    int          rels, fetches, n;
    logic [4:0]  mtab [8] = '{5'h14, 5'h0f, 5'h10, 5'h12, 5'h16, 5'h19, 5'h1b, 5'h1e};
    bmcs_row_t   rows [17];

    always #2.5 i_clk_sys = ~i_clk_sys;

    bmcs_boot_ctrl i_bmcs_boot_ctrl (.*);
    bmcs_boot_env i_bmcs_boot_env (
        .i_clk_sys        (i_clk_sys),
        .i_reset          (i_reset),
        .i_delay          (delay),
        .i_pll_enable     (o_system_pll_enable),
        .i_cache_disable  (o_cache_disable),
        .o_pll_locked     (i_pll_locked),
        .o_cache_off_done (i_cache_off_done)
    );

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            rels <= 0;
            fetches <= 0;
        end else begin
            if (o_core_release === 1'b1) rels <= rels + 1;
            if (o_fetch_start === 1'b1) fetches <= fetches + 1;
        end
    end
    // ==========================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic start(input bmcs_row_t r);
        i_reset = 1'b1;
        {i_boot_mode_pins, i_fast_boot_pin, i_pci_enable_pin} = {r.mode, r.fast, r.pci};
        {i_pll_multiplier_select_pins, i_async_pinout_select_pins} = {r.ms, r.pin};
        tick(2);
        i_reset = 1'b0;
    endtask
    // Bounded wait for done or invalid
    task automatic settle(output int k);
        k = 0;
        while (o_boot_done !== 1'b1 && o_boot_invalid !== 1'b1 && k < 80) begin
            tick(1);
            k++;
        end
        if (k >= 80) begin
            fails++;
            results();
        end
        tick(2);
    endtask
    task automatic run(input bmcs_row_t r);
        logic direct, rom, bad;
        start(r);
        settle(n);
        direct = r.mode == 4'h4 && !r.fast;
        rom = !r.inv && !direct && (r.mode == 4'h4 || r.mode == 4'h9 || r.mode == 4'h7);
        bad = (direct || rom) && r.pin != 3'h2 && !(r.mode == 4'h7 && r.pin == 3'h5);
        chk("pinout", bad, o_pinout_mismatch);
        chk("invalid", r.inv, o_boot_invalid);
        chk("capture", {12'h0, r.fast, 1'h0, r.pci, 2'h0, r.ms, 1'h0, r.pin, 4'h0, r.mode}, o_boot_strap_capture);
        chk("releases", !r.inv, rels);
        chk("second", 1'h0, o_second_pll_enable);
        chk("timing", 4'hf, o_async_timing);
        if (!r.inv) begin
            chk("start", direct ? 32'h4200_0000 : 32'h0010_0000, o_core_start_address);
            chk("pll_en", r.fast, o_system_pll_enable);
            chk("mult", r.fast ? mtab[r.ms] : 5'h01, o_system_pll_mult);
            chk("div", r.fast ? 2'h2 : 2'h1, o_core_clock_divider);
            chk("cache", !direct, o_cache_disable);
        end
        if (rom || direct) begin
            chk("fetches", rom, fetches);
            chk("if_mode", r.mode == 4'h7, o_async_if_mode);
        end
        if (rom) begin
            chk("fetch_addr", 32'h4200_0000, o_fetch_address);
            chk("script", r.mode != 4'h9, o_image_script_fetch);
        end
    endtask
    // ==========================================
    // Sequence
    initial begin
        // Straps of valid rows keep board rules: fast boot for PCI, pinout 2 for ROM, 2 or 5 for NAND
        rows = '{'{4'h4, 1'h0, 1'h0, 3'h0, 3'h2, 1'h0}, '{4'h4, 1'h1, 1'h0, 3'h0, 3'h2, 1'h0},
                 '{4'h9, 1'h1, 1'h0, 3'h1, 3'h2, 1'h0}, '{4'h7, 1'h1, 1'h0, 3'h2, 3'h5, 1'h0},
                 '{4'h7, 1'h0, 1'h0, 3'h3, 3'h2, 1'h0}, '{4'h0, 1'h1, 1'h1, 3'h3, 3'h2, 1'h0},
                 '{4'h5, 1'h1, 1'h0, 3'h4, 3'h2, 1'h0}, '{4'h6, 1'h1, 1'h0, 3'h5, 3'h2, 1'h0},
                 '{4'h8, 1'h1, 1'h0, 3'h6, 3'h2, 1'h0}, '{4'he, 1'h1, 1'h0, 3'h7, 3'h2, 1'h0},
                 '{4'h2, 1'h1, 1'h1, 3'h0, 3'h2, 1'h0}, '{4'h3, 1'h0, 1'h0, 3'h0, 3'h2, 1'h1},
                 '{4'hb, 1'h1, 1'h0, 3'h0, 3'h2, 1'h1}, '{4'hc, 1'h0, 1'h1, 3'h0, 3'h2, 1'h1},
                 '{4'hd, 1'h1, 1'h0, 3'h0, 3'h2, 1'h1}, '{4'h1, 1'h0, 1'h1, 3'h0, 3'h2, 1'h1},
                 '{4'h9, 1'h0, 1'h0, 3'h0, 3'h2, 1'h1}};
        tick(2);
        chk("rst_pll", 1'h0, o_system_pll_enable);
        chk("rst_mult", 5'h01, o_system_pll_mult);
        chk("rst_addr", 32'h0010_0000, o_core_start_address);
        foreach (rows[i]) run(rows[i]);
        // Late strap change must not reach the capture
        run(rows[0]);
        i_boot_mode_pins = 4'h7;
        tick(8);
        chk("held_mode", 4'h4, o_boot_strap_capture[3:0]);
        chk("held_addr", 32'h4200_0000, o_core_start_address);
        // Wrong pinout straps must raise the mismatch flag
        run(bmcs_row_t'{4'h4, 1'h0, 1'h0, 3'h0, 3'h5, 1'h0});
        run(bmcs_row_t'{4'h7, 1'h1, 1'h0, 3'h2, 3'h0, 1'h0});
        // Slow lock holds the fetch back
        delay = 4'hc;
        start(rows[1]);
        settle(n);
        // Lock wait and cache wait both of 12 cycles must come before done
        chk("slow_lock", 1'h1, n > 24);
        delay = 4'h2;
        // Second reset in mid-boot
        start(rows[2]);
        tick(5);
        i_reset = 1'b1;
        tick(2);
        chk("mid_pll", 1'h0, o_system_pll_enable);
        i_reset = 1'b0;
        settle(n);
        chk("mid_done", 1'h1, o_boot_done);
        results();
    end
endmodule
